// ==== pkg/lcg_cfg.svh ====
`ifndef LCG_CFG_SVH
`define LCG_CFG_SVH

// ==========================================================
// register map, byte addresses on the avalon slave
`define LCG_ADDR_W 8
`define LCG_GATE3_ADDR 8'h00
`define LCG_GATE4_ADDR 8'h04

// ==========================================================
// reset values: select registers by power-on / brown-out reset, read data by system reset
`define LCG_SEL_POR_VAL 8'h00
`define LCG_RDATA_IDLE 32'h0000_0000

// ==========================================================
// select bit positions inside each gate select register
`define LCG_IN4_TRUE_BIT 7
`define LCG_IN4_INV_BIT 6
`define LCG_IN3_TRUE_BIT 5
`define LCG_IN3_INV_BIT 4
`define LCG_IN2_TRUE_BIT 3
`define LCG_IN2_INV_BIT 2
`define LCG_IN1_TRUE_BIT 1
`define LCG_IN1_INV_BIT 0

// ==========================================================
// widths
`define LCG_SEL_W 8
`define LCG_DATA_IN_N 4

`endif

// ==== pkg/lcg_pkg.sv ====
`include "lcg_cfg.svh"

// ==========================================================
// shared types of the gate input select block
package lcg_pkg;
  typedef logic [`LCG_SEL_W-1:0] sel_t;
  typedef logic [`LCG_DATA_IN_N-1:0] data_t;
  typedef logic [`LCG_ADDR_W-1:0] addr_t;
endpackage : lcg_pkg

// ==== verilog/gate_or_select.sv ====
`timescale 1ns/1ps
`include "lcg_cfg.svh"

// ==========================================================
// one and-or gate: or of the enabled true / inverted data terms
module gate_or_select #(
  parameter int N_INPUTS = `LCG_DATA_IN_N
) (
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic [2*N_INPUTS-1:0] i_sel, // odd bit true enable, even bit inverted enable
  input wire logic [N_INPUTS-1:0] i_data, // true form of each data input
  output logic o_gate // registered gate output
);
  // ==========================================================
  // elaboration check
  if (N_INPUTS < 1) begin : g_bad_n
    $error("gate_or_select needs at least one data input");
  end

  // interleave true and inverted forms to match select layout
  function automatic logic [2*N_INPUTS-1:0] both_forms(input logic [N_INPUTS-1:0] d);
    logic [2*N_INPUTS-1:0] f;
    f = '0;
    for (int k = 0; k < N_INPUTS; k++) begin
      f[2*k+1] = d[k];
      f[2*k] = ~d[k];
    end
    return f;
  endfunction : both_forms

  // ==========================================================
  // gated terms combined by or
  wire logic [2*N_INPUTS-1:0] terms = both_forms(i_data) & i_sel;
  wire logic next_gate = |terms;

  // output flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_gate <= 1'b0;
    end else begin
      o_gate <= next_gate;
    end
  end
endmodule : gate_or_select

// ==== verilog/logic_cell_gate_sel.sv ====
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "lcg_cfg.svh"

module logic_cell_gate_sel (
  input wire logic i_clk, // system clock, 250 mhz
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_por, // power-on / brown-out reset, active high
  input wire lcg_pkg::addr_t i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte enables
  output logic [31:0] o_avs_readdata, // registered read data
  output logic o_avs_waitrequest, // stall, low on answer cycle
  input wire lcg_pkg::data_t i_data_in_true, // true forms of data inputs 1..4
  output logic o_gate_three_out, // gate 3 output, registered
  output logic o_gate_four_out // gate 4 output, registered
);
  import lcg_pkg::*;

  // ==========================================================
  // select registers
  sel_t gate3_input_select;
  sel_t gate4_input_select;
  logic ack;

  // ==========================================================
  // bus decode
  wire logic req = i_avs_read | i_avs_write;
  wire logic hit3 = (i_avs_address == `LCG_GATE3_ADDR);
  wire logic hit4 = (i_avs_address == `LCG_GATE4_ADDR);
  wire logic wr_go = i_avs_write & ack & i_avs_byteenable[0];
  wire logic wr3 = wr_go & hit3;
  wire logic wr4 = wr_go & hit4;
  wire sel_t wbyte = i_avs_writedata[`LCG_SEL_W-1:0];
  wire sel_t rd_sel = hit3 ? gate3_input_select : (hit4 ? gate4_input_select : '0);
  wire logic [31:0] next_readdata = {24'h00_0000, rd_sel};

  // one wait state: answer on the second cycle of a request
  assign o_avs_waitrequest = req & ~ack;

  // ack toggles high for exactly the answer cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= `LCG_RDATA_IDLE;
    end else if (i_avs_read & ~ack) begin
      o_avs_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // register storage, untouched by the system reset
  // only power-on clears
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      gate3_input_select <= `LCG_SEL_POR_VAL;
    end else if (wr3) begin
      gate3_input_select <= wbyte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_por) begin
      gate4_input_select <= `LCG_SEL_POR_VAL;
    end else if (wr4) begin
      gate4_input_select <= wbyte;
    end
  end

  // ==========================================================
  // gate 3 and gate 4 and-or stages
  // gate three terms
  gate_or_select #(
    .N_INPUTS(`LCG_DATA_IN_N)
  ) u_gate3 (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sel(gate3_input_select),
    .i_data(i_data_in_true),
    .o_gate(o_gate_three_out)
  );

  gate_or_select #(
    .N_INPUTS(`LCG_DATA_IN_N)
  ) u_gate4 (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sel(gate4_input_select),
    .i_data(i_data_in_true),
    .o_gate(o_gate_four_out)
  );

  // ==========================================================
  // assertions
  wire logic d1 = i_data_in_true[0];
  wire logic d2 = i_data_in_true[1];
  wire logic d3 = i_data_in_true[2];
  wire logic d4 = i_data_in_true[3];

  g3_in3_true_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate3_input_select[`LCG_IN3_TRUE_BIT] && d3 |=> o_gate_three_out)
    else $error("gate 3 missed true input 3");

  g3_in3_inv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate3_input_select[`LCG_IN3_INV_BIT] && !d3 |=> o_gate_three_out)
    else $error("gate 3 missed inverted input 3");

  g3_in2_both_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (gate3_input_select[`LCG_IN2_TRUE_BIT] && d2)
    || (gate3_input_select[`LCG_IN2_INV_BIT] && !d2) |=> o_gate_three_out)
    else $error("gate 3 missed input 2 term");

  g3_in1_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate3_input_select == 8'h02 |=> o_gate_three_out == $past(d1))
    else $error("gate 3 does not follow true input 1");

  g3_in1_inv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate3_input_select == 8'h01 |=> o_gate_three_out == !$past(d1))
    else $error("gate 3 does not follow inverted input 1");

  g3_none_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate3_input_select == 8'h00 |=> !o_gate_three_out)
    else $error("gate 3 high with nothing selected");

  g4_in4_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate4_input_select == 8'h80 |=> o_gate_four_out == $past(d4))
    else $error("gate 4 does not follow true input 4");

  g4_in4_inv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate4_input_select[`LCG_IN4_INV_BIT] && !d4 |=> o_gate_four_out)
    else $error("gate 4 missed inverted input 4");

  g4_in32_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (gate4_input_select[`LCG_IN3_TRUE_BIT] && d3)
    || (gate4_input_select[`LCG_IN3_INV_BIT] && !d3)
    || (gate4_input_select[`LCG_IN2_TRUE_BIT] && d2)
    || (gate4_input_select[`LCG_IN2_INV_BIT] && !d2) |=> o_gate_four_out)
    else $error("gate 4 missed input 3 or 2 term");

  g4_in2_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate4_input_select == 8'h08 |=> o_gate_four_out == $past(d2))
    else $error("gate 4 does not follow true input 2");

  g4_in1_inv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate4_input_select == 8'h01 |=> o_gate_four_out == !$past(d1))
    else $error("gate 4 does not follow inverted input 1");

  g4_none_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    gate4_input_select == 8'h00 |=> !o_gate_four_out)
    else $error("gate 4 high with nothing selected");

  wr_readback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
    wr3 |=> gate3_input_select == $past(wbyte))
    else $error("gate 3 select write lost");

  wr4_readback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
    wr4 |=> gate4_input_select == $past(wbyte))
    else $error("gate 4 select write lost");

  no_lane_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
    i_avs_write && ack && !i_avs_byteenable[0]
    |=> $stable(gate3_input_select) && $stable(gate4_input_select))
    else $error("select changed by write without lane 0");

  unmapped_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
    i_avs_write && ack && !hit3 && !hit4
    |=> $stable(gate3_input_select) && $stable(gate4_input_select))
    else $error("select changed by unmapped write");

  rst_keeps_a: assert property (@(posedge i_clk) disable iff (i_por)
    i_sys_rst && !wr_go |=> $stable(gate4_input_select))
    else $error("gate 4 select changed across system reset");

  bus_answer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not on second cycle");

  read_data_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
    i_avs_read && ack && hit4 |-> o_avs_readdata[7:0] == gate4_input_select)
    else $error("read data wrong for gate 4 select");

  // ==========================================================
  // covers
  cov_wr3_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) wr3);
  cov_no_lane_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_avs_write && ack && !i_avs_byteenable[0]);
  cov_rd4_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_avs_read && ack && hit4);
  cov_g3_hi_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_gate_three_out));
  cov_g4_hi_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_gate_four_out));
endmodule : logic_cell_gate_sel

// ==== bench/data_src_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// data input selector model: launches the wanted pattern each edge
module data_src_model (
  input wire logic i_clk, // system clock
  input wire lcg_pkg::data_t i_want, // pattern asked for by the bench
  output lcg_pkg::data_t o_data // true forms of data inputs 1..4
);
  import lcg_pkg::*;
  // registered like a real selector stage, so changes land after an edge
  always_ff @(posedge i_clk) begin
    o_data <= i_want;
  end
endmodule : data_src_model

// ==== bench/test_logic_cell_gate_sel.sv ====
`timescale 1ns/1ps
`include "lcg_cfg.svh"

// ==========================================================
// bench for the gate 3 / gate 4 input select block
module test_logic_cell_gate_sel;
  import lcg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por = 1'b1;
  addr_t avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  data_t want = '0;
  data_t data_in;
  logic gate_three;
  logic gate_four;
  int errors = 0;
  int checked = 0;
  logic [31:0] rd;

  // 250 mhz clock
  always #2 clk = ~clk;

  data_src_model src (.i_clk(clk), .i_want(want), .o_data(data_in));

  logic_cell_gate_sel dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_por(por),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_data_in_true(data_in), .o_gate_three_out(gate_three), .o_gate_four_out(gate_four)
  );

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input addr_t a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      check(1'b1, 1'b0);
      stop_test();
    end else begin
      check(n, 2);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask : bus

  // or of enabled true / inverted terms, bit 7 is input 4 true
  function automatic logic gexp(input sel_t s, input data_t d);
    gexp = |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
  endfunction : gexp

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  // ==========================================================
  // test sequence
  initial begin
    sel_t sel;
    repeat (12) @(posedge clk);
    por <= 1'b0;
    sys_rst <= 1'b0;
    bus(1'b0, `LCG_GATE3_ADDR, '0, 4'hf, rd);
    check(rd, {24'h0, `LCG_SEL_POR_VAL});
    bus(1'b0, `LCG_GATE4_ADDR, '0, 4'hf, rd);
    check(rd, {24'h0, `LCG_SEL_POR_VAL});
    // each select bit alone, every data pattern, both gates
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 8; b++) begin
        sel = 8'h01 << b;
        bus(1'b1, g ? `LCG_GATE4_ADDR : `LCG_GATE3_ADDR, {24'h0, sel}, 4'h1, rd);
        bus(1'b1, g ? `LCG_GATE3_ADDR : `LCG_GATE4_ADDR, 32'h0, 4'h1, rd);
        for (int d = 0; d < 16; d++) begin
          @(posedge clk);
          want <= d[3:0];
          repeat (3) @(posedge clk);
          #1;
          check(gate_three, g ? 1'b0 : gexp(sel, d[3:0]));
          check(gate_four, g ? gexp(sel, d[3:0]) : 1'b0);
        end
      end
    end
    // readback, lane 0 gating, unmapped place, sys reset keeps selects
    bus(1'b1, `LCG_GATE3_ADDR, 32'hffff_ffa5, 4'h1, rd);
    bus(1'b1, `LCG_GATE4_ADDR, 32'h0000_005a, 4'h1, rd);
    bus(1'b1, `LCG_GATE4_ADDR, 32'h0000_00ff, 4'he, rd);
    bus(1'b1, 8'h08, 32'h0000_0011, 4'h1, rd);
    bus(1'b0, 8'h08, '0, 4'hf, rd);
    check(rd, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, `LCG_GATE3_ADDR, '0, 4'hf, rd);
    check(rd, 32'h0000_00a5);
    bus(1'b0, `LCG_GATE4_ADDR, '0, 4'hf, rd);
    check(rd, 32'h0000_005a);
    stop_test();
  end
endmodule : test_logic_cell_gate_sel
